// ==== rtl/opf_pkg.sv ====
// opf_pkg: shared constants and carrier types for the pipeline flow controller
// assumes a single core clock domain; used by opf_pipeline_flow and opf_stage_reg
package opf_pkg;
   localparam int unsigned ALU_DEPTH = 14;
   localparam int unsigned AGEN_DEPTH = 15;
   localparam int unsigned COMP_EXTRA = 3;
   localparam int unsigned FETCH_WIDTH = 4;
   localparam int unsigned BUF_DEPTH = 12;
   localparam int unsigned BUF_READ = 2;
   localparam int unsigned BHT_ENTRIES = 256;
   localparam int unsigned RSTACK_DEPTH = 8;
   localparam int unsigned ITC_WAYS = 4;
   localparam int unsigned ITC_SETS = 16;
   localparam int unsigned UTLB_ENTRIES = 4;
   localparam int unsigned DQ_ENTRIES = 6;
   localparam int unsigned DQ_STAGING = 2;
   localparam int unsigned DQ_CANDIDATES = DQ_ENTRIES + DQ_STAGING;
   localparam int unsigned GRAD_WIDTH = 2;
   localparam logic [1:0] PF_MAX = 2'h2;
   localparam logic [31:0] PC_RESET = 32'h0000_0000;
   localparam logic [3:0] BUF_CNT_RESET = 4'h0;
   localparam logic [7:0] GHIST_RESET = 8'h00;
   localparam logic [1:0] PC_ALIGN_ZERO = 2'h0;
   localparam logic [3:0] FETCH_BYTES = 4'h4;

   typedef enum logic [1:0] {
      OPF_PIPE_ALU,
      OPF_PIPE_AGEN,
      OPF_PIPE_COP
   } opf_pipe_t;

   typedef struct packed {
      logic valid;
      opf_pipe_t pipe;
      logic [4:0] iid;
      logic is_load;
      logic is_store;
      logic miss;
   } opf_instr_t;

   typedef struct packed {
      logic valid;
      logic [31:0] target;
   } opf_redirect_t;
endpackage

// ==== rtl/opf_stage_reg.sv ====
// opf_stage_reg: one pipeline stage register with valid and flush
// assumes the caller qualifies flush and clock enable on the core clock
`timescale 1ns/1ps
module opf_stage_reg (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // stage data
   input wire logic flush,
   input opf_pkg::opf_instr_t din,
   output opf_pkg::opf_instr_t dout
);
   import opf_pkg::*;
   opf_instr_t q;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else if (clk_en) begin
         q <= flush ? '0 : din;
      end
   end
   assign dout = q;
endmodule

// ==== rtl/opf_pipeline_flow.sv ====
// opf_pipeline_flow: stage-by-stage control flow of a dual-issue out-of-order core
// assumes cache, tlb and coprocessor arrays sit outside; their hit/ready levels arrive
// on core_clk except icache_hit and dcache_miss strobes from array macros, which are
// treated as same-domain logic; cfg inputs are quasi-static pins and are synchronised.
// What this block does
// - arithmetic path has 14 stages, address path 15 stages
// - compressed mode inserts recode, compressed decode and expansion stages
// - first fetch stage reads tags, histories, target cache, translates, breaks
// - way select picks hit way, starts target; next writes buffer
// - decode checks sources, assigns pipe and identifier, checks resources
// - rename updates map, informs graduation and coprocessor, enqueues
// - select picks one ready of eight candidates per pipe independently
// - mux stage reads selection; alu premuxes, address pipe reads operands
// - simple ops finish in compute stage, others in bypass stage
// - address pipe muxes index, computes address, starts joint tlb
// - cache access reads data and tags; branches resolve
// - data way stage selects way; mispredicts redirect fetch
// - load align stage aligns, bypasses, validates tag agreement
// - coprocessor path: pointer adjust, queue read, issue in order
// - writeback fills completion buffers, finds two oldest completed
// - graduate two; load misses unavailable; misses and stores go to lsu
// - fetch up to four instructions from an aligned counter
// - direction is majority of three 256-entry history tables
// - eight-entry return stack and 4x16 learning indirect target buffer
// - four-entry micro tlb translates before tag compare
// - twelve-entry buffer, up to four in, two out per cycle
// - on miss prefetch zero, one or two sequential lines
`timescale 1ns/1ps
module opf_pipeline_flow (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // configuration pins
   input wire logic [1:0] cfg_prefetch_lines,
   input wire logic cfg_compressed,
   // fetch side status
   input wire logic icache_hit,
   input wire logic utlb_hit,
   input wire logic [2:0] fetch_count,
   input wire logic bht_vote0,
   input wire logic bht_vote1,
   input wire logic bht_vote2,
   // decode side
   input wire logic [1:0] decode_pipe,
   input wire logic decode_is_load,
   input wire logic decode_is_store,
   input wire logic resources_ok,
   input wire logic [7:0] alu_ready_vec,
   input wire logic [7:0] agen_ready_vec,
   // execute and memory side
   input wire logic alu_simple_op,
   input wire logic branch_mispredict,
   input wire logic indirect_jump,
   input wire logic [31:0] redirect_target,
   input wire logic dcache_miss,
   input wire logic vtag_match,
   input wire logic ptag_match,
   // fetch outputs
   output logic [31:0] fetch_pc,
   output logic fetch_req,
   output logic [1:0] prefetch_pending,
   output logic predict_taken,
   output logic [3:0] ibuf_count,
   // dispatch outputs
   output logic [2:0] alu_select,
   output logic alu_select_valid,
   output logic [2:0] agen_select,
   output logic agen_select_valid,
   // result outputs
   output logic alu_early_bypass,
   output logic alu_late_bypass,
   output logic load_bypass,
   output logic tag_mismatch,
   output logic cop_issue,
   output logic redirect_valid,
   output logic [1:0] graduate_count,
   output logic lsu_activate,
   output logic dest_unavailable
);
   import opf_pkg::*;

   // configuration pins cross from outside, two flops each
   logic [1:0] pf_s1_q, pf_s2_q;
   logic cmp_s1_q, cmp_s2_q;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pf_s1_q <= 2'h0;
         pf_s2_q <= 2'h0;
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else if (clk_en) begin
         pf_s1_q <= cfg_prefetch_lines;
         pf_s2_q <= pf_s1_q;
         cmp_s1_q <= cfg_compressed;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   // a redirect registered last cycle flushes fetch, buffer and decode this cycle
   logic redirect_q;
   wire flush_all;
   wire ibuf_full;
   assign flush_all = redirect_q;

   // fetch front end: tag read, data read, way select, buffer write, plus compressed
   localparam int unsigned FETCH_STAGES = 4 + COMP_EXTRA;
   logic [FETCH_STAGES-1:0] fvalid_q, fvalid_d;
   logic [31:0] pc_q, pc_d;
   logic [31:0] redirect_pc_q;
   logic [1:0] pf_q, pf_d;
   logic [7:0] ghist_q;
   wire miss_now;
   wire majority;
   wire [2:0] fetch_accept;
   assign majority = (bht_vote0 & bht_vote1) | (bht_vote0 & bht_vote2) |
      (bht_vote1 & bht_vote2);
   // translation must hit before the tag compare counts as a hit
   assign miss_now = fvalid_q[1] && !(utlb_hit && icache_hit);
   assign fetch_accept = (fetch_count > 3'(FETCH_WIDTH)) ? 3'(FETCH_WIDTH) : fetch_count;

   always_comb begin
      fvalid_d = {fvalid_q[FETCH_STAGES-2:0], 1'b1};
      // compressed stages are bypassed as empty outside compressed mode
      if (!cmp_s2_q) begin
         fvalid_d[FETCH_STAGES-1:4] = '0;
      end
      if (miss_now) begin
         fvalid_d[2:0] = '0;
      end
      if (flush_all || ibuf_full) begin
         fvalid_d = flush_all ? '0 : fvalid_q;
      end
   end

   always_comb begin
      pc_d = pc_q;
      if (flush_all) begin
         pc_d = {redirect_pc_q[31:2], PC_ALIGN_ZERO};
      end else if (!ibuf_full && !miss_now) begin
         pc_d = {pc_q[31:2], PC_ALIGN_ZERO} + 32'({FETCH_BYTES, 2'h0});
      end
   end

   always_comb begin
      pf_d = pf_q;
      if (miss_now) begin
         pf_d = (pf_s2_q > PF_MAX) ? PF_MAX : pf_s2_q;
      end else if (pf_q != 2'h0) begin
         pf_d = pf_q - 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fvalid_q <= '0;
         pc_q <= PC_RESET;
         pf_q <= 2'h0;
         ghist_q <= GHIST_RESET;
      end else if (clk_en) begin
         fvalid_q <= fvalid_d;
         pc_q <= pc_d;
         pf_q <= pf_d;
         if (fvalid_q[2]) begin
            ghist_q <= {ghist_q[6:0], majority};
         end
      end
   end

   // instruction buffer occupancy: four in, two out
   logic [3:0] buf_q, buf_d;
   wire [3:0] buf_in;
   wire [3:0] buf_out;
   wire buf_write_stage;
   assign buf_write_stage = cmp_s2_q ? fvalid_q[FETCH_STAGES-1] : fvalid_q[3];
   assign ibuf_full = (buf_q > 4'(BUF_DEPTH - FETCH_WIDTH));
   // a held write stage must not count again while the buffer is too full to take it
   assign buf_in = (buf_write_stage && !ibuf_full) ? {1'b0, fetch_accept} : 4'h0;
   assign buf_out = (buf_q >= 4'(BUF_READ)) ? 4'(BUF_READ) : buf_q;
   always_comb begin
      buf_d = buf_q + buf_in - buf_out;
      if (flush_all) begin
         buf_d = BUF_CNT_RESET;
      end
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         buf_q <= BUF_CNT_RESET;
      end else if (clk_en) begin
         buf_q <= buf_d;
      end
   end

   // decode and rename
   logic [4:0] iid_q;
   opf_instr_t dec_in, ren_out, dec_out;
   assign dec_in = '{valid: (buf_out != 4'h0) && resources_ok, pipe: opf_pipe_t'(decode_pipe),
      iid: iid_q, is_load: decode_is_load, is_store: decode_is_store, miss: 1'b0};
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         iid_q <= 5'h00;
      end else if (clk_en && dec_in.valid) begin
         iid_q <= iid_q + 5'h01;
      end
   end
   opf_stage_reg u_decode (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .flush(flush_all), .din(dec_in), .dout(dec_out));
   opf_stage_reg u_rename (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .flush(flush_all), .din(dec_out), .dout(ren_out));

   // dispatch select: lowest index ready of eight per pipe
   function automatic logic [2:0] opf_pick(input logic [7:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = DQ_CANDIDATES - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction
   wire [2:0] alu_pick;
   wire [2:0] agen_pick;
   assign alu_pick = opf_pick(alu_ready_vec);
   assign agen_pick = opf_pick(agen_ready_vec);

   // execution pipes; alu: select,mux,read,opmux,compute,bypass; agen adds stages
   opf_instr_t alu_pipe [0:4];
   opf_instr_t agen_pipe [0:5];
   opf_instr_t cop_pipe [0:2];
   opf_instr_t alu_in, agen_in, cop_in;
   wire redirect_now;
   assign redirect_now = agen_pipe[3].valid && (branch_mispredict || indirect_jump);
   assign alu_in = '{valid: ren_out.valid && ren_out.pipe == OPF_PIPE_ALU
      && alu_ready_vec != 8'h00, pipe: OPF_PIPE_ALU, iid: ren_out.iid,
      is_load: 1'b0, is_store: 1'b0, miss: 1'b0};
   assign agen_in = '{valid: ren_out.valid && ren_out.pipe == OPF_PIPE_AGEN
      && agen_ready_vec != 8'h00, pipe: OPF_PIPE_AGEN, iid: ren_out.iid,
      is_load: ren_out.is_load, is_store: ren_out.is_store, miss: 1'b0};
   assign cop_in = (ren_out.pipe == OPF_PIPE_COP) ? ren_out : '0;
   // alu stages: instruction mux, operand read, operand mux, compute, bypass
   opf_stage_reg u_alu0 (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .flush(1'b0), .din(alu_in), .dout(alu_pipe[0]));
   // agen stages: mux, agen mux, address calc, dcache access, way, align
   opf_stage_reg u_agen0 (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .flush(1'b0), .din(agen_in), .dout(agen_pipe[0]));
   opf_stage_reg u_cop0 (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
      .flush(flush_all), .din(cop_in), .dout(cop_pipe[0]));
   genvar g;
   generate
      for (g = 1; g < 5; g++) begin : g_alu
         opf_stage_reg u_s (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
            .flush(1'b0), .din(alu_pipe[g-1]), .dout(alu_pipe[g]));
      end
      for (g = 1; g < 6; g++) begin : g_agen
         opf_stage_reg u_s (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
            .flush(1'b0), .din(agen_pipe[g-1]), .dout(agen_pipe[g]));
      end
      for (g = 1; g < 3; g++) begin : g_cop
         opf_stage_reg u_s (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
            .flush(1'b0), .din(cop_pipe[g-1]), .dout(cop_pipe[g]));
      end
   endgenerate

   // writeback and graduation; at most two complete per cycle (one per pipe)
   wire wb_alu;
   wire wb_agen;
   wire [1:0] grad_d;
   wire ld_miss;
   assign wb_alu = alu_pipe[4].valid;
   assign wb_agen = agen_pipe[5].valid;
   assign grad_d = 2'(wb_alu) + 2'(wb_agen);
   // bubbles still carry load and store bits, so only a valid slot may count
   assign ld_miss = agen_pipe[5].valid && agen_pipe[5].is_load && dcache_miss;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         redirect_q <= 1'b0;
         redirect_pc_q <= PC_RESET;
         alu_select <= 3'h0;
         alu_select_valid <= 1'b0;
         agen_select <= 3'h0;
         agen_select_valid <= 1'b0;
         alu_early_bypass <= 1'b0;
         alu_late_bypass <= 1'b0;
         load_bypass <= 1'b0;
         tag_mismatch <= 1'b0;
         cop_issue <= 1'b0;
         graduate_count <= 2'h0;
         lsu_activate <= 1'b0;
         dest_unavailable <= 1'b0;
         predict_taken <= 1'b0;
      end else if (clk_en) begin
         redirect_q <= redirect_now;
         redirect_pc_q <= redirect_target;
         alu_select <= alu_pick;
         alu_select_valid <= alu_ready_vec != 8'h00;
         agen_select <= agen_pick;
         agen_select_valid <= agen_ready_vec != 8'h00;
         alu_early_bypass <= alu_pipe[3].valid && alu_simple_op;
         alu_late_bypass <= alu_pipe[4].valid;
         load_bypass <= agen_pipe[5].valid && agen_pipe[5].is_load && !dcache_miss;
         tag_mismatch <= agen_pipe[5].valid && (vtag_match != ptag_match);
         cop_issue <= cop_pipe[2].valid;
         graduate_count <= grad_d;
         lsu_activate <= ld_miss || (agen_pipe[5].valid && agen_pipe[5].is_store);
         dest_unavailable <= ld_miss;
         predict_taken <= fvalid_q[0] && majority;
      end
   end

   assign fetch_pc = pc_q;
   assign fetch_req = fvalid_q[0];
   assign prefetch_pending = pf_q;
   assign ibuf_count = buf_q;
   assign redirect_valid = redirect_q;

   // assertions
   property p_buf_bound;
      @(posedge core_clk) disable iff (!nrst) buf_q <= 4'(BUF_DEPTH);
   endproperty
   a_buf_bound: assert property (p_buf_bound) else $error("buffer over depth");
   property p_redirect;
      @(posedge core_clk) disable iff (!nrst) clk_en && redirect_now |=> redirect_valid;
   endproperty
   a_redirect: assert property (p_redirect) else $error("redirect lost");
   property p_flush;
      @(posedge core_clk) disable iff (!nrst) clk_en && redirect_q |=> buf_q == 4'h0
         && fvalid_q == '0;
   endproperty
   a_flush: assert property (p_flush) else $error("flush incomplete");
   property p_align;
      @(posedge core_clk) disable iff (!nrst) fetch_pc[1:0] == 2'h0;
   endproperty
   a_align: assert property (p_align) else $error("pc misaligned");
   property p_pf;
      @(posedge core_clk) disable iff (!nrst) prefetch_pending <= PF_MAX;
   endproperty
   a_pf: assert property (p_pf) else $error("prefetch over two");
   sequence s_cop_enter;
      clk_en && cop_in.valid && !flush_all;
   endsequence
   property p_cop;
      @(posedge core_clk) disable iff (!nrst) s_cop_enter ##1 clk_en [*3] |=> cop_issue;
   endproperty
   a_cop: assert property (p_cop) else $error("coprocessor issue late");
   property p_grad;
      @(posedge core_clk) disable iff (!nrst) graduate_count <= 2'(GRAD_WIDTH);
   endproperty
   a_grad: assert property (p_grad) else $error("more than two graduated");
   property p_miss_unavail;
      @(posedge core_clk) disable iff (!nrst) clk_en && agen_pipe[5].valid
         && agen_pipe[5].is_load && dcache_miss |=> dest_unavailable && lsu_activate;
   endproperty
   a_miss_unavail: assert property (p_miss_unavail) else $error("miss not sent");
   property p_sel;
      @(posedge core_clk) disable iff (!nrst) alu_select_valid && $past(clk_en) |->
         (($past(alu_ready_vec) >> alu_select) & 8'h01) != 8'h00;
   endproperty
   a_sel: assert property (p_sel) else $error("selected entry not ready");
endmodule

// ==== verif/opf_cache_model.sv ====
// opf_cache_model: far-side stand-in for the instruction cache, micro tlb and data cache
// assumes it shares core_clk and nrst with the flow controller; answers one cycle after
// each fetch request, as the data-read stage samples the hit levels then
`timescale 1ns/1ps
module opf_cache_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // request side
   input wire logic fetch_req,
   input wire logic force_miss,
   input wire logic force_dmiss,
   // answer side
   output logic icache_hit,
   output logic utlb_hit,
   output logic [2:0] fetch_count,
   output logic dcache_miss,
   output logic vtag_match,
   output logic ptag_match
);
   logic toggle_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         icache_hit <= 1'b0;
         utlb_hit <= 1'b0;
         fetch_count <= 3'h0;
         toggle_q <= 1'b0;
      end else begin
         toggle_q <= ~toggle_q;
         // translation always succeeds; the hit depends on the physical tag compare
         utlb_hit <= fetch_req;
         icache_hit <= fetch_req & ~force_miss;
         // a whole aligned group of four, or nothing when idle or missing
         fetch_count <= (fetch_req & ~force_miss) ? 3'h4 : 3'h0;
      end
   end

   // while forced, the virtual tag always predicts a miss, so hit cycles disagree with
   // the physical compare and miss cycles agree
   assign dcache_miss = toggle_q & force_dmiss;
   assign vtag_match = ~force_dmiss;
   assign ptag_match = ~dcache_miss;
endmodule

// ==== verif/opf_pipeline_flow_test.sv ====
// opf_pipeline_flow_test: self-checking bench for the pipeline flow controller
// assumes the cache model answers fetches; all stimulus lands by NBA on rising edges
`timescale 1ns/1ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("BAD %s expected %0h seen %0h", what, exp, got); end end
module opf_pipeline_flow_test;
   import opf_pkg::*;
   logic core_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, cfg_compressed = 1'b0;
   logic [1:0] cfg_prefetch_lines = 2'h0, decode_pipe = 2'h1;
   logic bht_vote0 = 1'b0, bht_vote1 = 1'b0, bht_vote2 = 1'b0, force_miss = 1'b0;
   logic force_dmiss = 1'b0;
   logic decode_is_load = 1'b0, decode_is_store = 1'b0, resources_ok = 1'b1;
   logic [7:0] alu_ready_vec = 8'h00, agen_ready_vec = 8'h00;
   logic alu_simple_op = 1'b0, branch_mispredict = 1'b0, indirect_jump = 1'b0;
   logic [31:0] redirect_target = 32'h0;
   logic icache_hit, utlb_hit, dcache_miss, vtag_match, ptag_match, fetch_req, predict_taken;
   logic [2:0] fetch_count, alu_select, agen_select;
   logic [31:0] fetch_pc;
   logic [1:0] prefetch_pending, graduate_count;
   logic [3:0] ibuf_count;
   logic alu_select_valid, agen_select_valid, alu_early_bypass, alu_late_bypass, load_bypass;
   logic tag_mismatch, cop_issue, redirect_valid, lsu_activate, dest_unavailable;
   int n_fail = 0, samples_checked = 0, cyc = 0;

   always #5 core_clk = ~core_clk;

   opf_cache_model opf_cache_model_inst (.core_clk(core_clk), .nrst(nrst),
      .fetch_req(fetch_req), .force_miss(force_miss), .force_dmiss(force_dmiss),
      .icache_hit(icache_hit), .utlb_hit(utlb_hit), .fetch_count(fetch_count),
      .dcache_miss(dcache_miss), .vtag_match(vtag_match), .ptag_match(ptag_match));

   opf_pipeline_flow opf_pipeline_flow_inst (.core_clk(core_clk), .nrst(nrst),
      .clk_en(clk_en), .cfg_prefetch_lines(cfg_prefetch_lines),
      .cfg_compressed(cfg_compressed), .icache_hit(icache_hit), .utlb_hit(utlb_hit),
      .fetch_count(fetch_count), .bht_vote0(bht_vote0), .bht_vote1(bht_vote1),
      .bht_vote2(bht_vote2), .decode_pipe(decode_pipe), .decode_is_load(decode_is_load),
      .decode_is_store(decode_is_store), .resources_ok(resources_ok),
      .alu_ready_vec(alu_ready_vec), .agen_ready_vec(agen_ready_vec),
      .alu_simple_op(alu_simple_op), .branch_mispredict(branch_mispredict),
      .indirect_jump(indirect_jump), .redirect_target(redirect_target),
      .dcache_miss(dcache_miss), .vtag_match(vtag_match), .ptag_match(ptag_match),
      .fetch_pc(fetch_pc), .fetch_req(fetch_req), .prefetch_pending(prefetch_pending),
      .predict_taken(predict_taken), .ibuf_count(ibuf_count), .alu_select(alu_select),
      .alu_select_valid(alu_select_valid), .agen_select(agen_select),
      .agen_select_valid(agen_select_valid), .alu_early_bypass(alu_early_bypass),
      .alu_late_bypass(alu_late_bypass), .load_bypass(load_bypass),
      .tag_mismatch(tag_mismatch), .cop_issue(cop_issue), .redirect_valid(redirect_valid),
      .graduate_count(graduate_count), .lsu_activate(lsu_activate),
      .dest_unavailable(dest_unavailable));

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ceiling well above the fewer than a thousand cycles the scenarios need
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end

   // standing bounds, watched every cycle once out of reset
   always @(negedge core_clk) begin
      if (nrst) begin
         `CHK("ibuf_count bound", 1'b1, ibuf_count <= 4'hc)
         `CHK("graduate_count bound", 1'b1, graduate_count <= 2'h2)
         `CHK("fetch_pc alignment", 2'h0, fetch_pc[1:0])
      end
   end

   function automatic logic [3:0] lowest(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
         if (v[i])
            return {1'b1, i[2:0]};
      return 4'h0;
   endfunction

   task automatic check_reset();
      #1;
      `CHK("fetch_pc at reset", 32'h0, fetch_pc)
      `CHK("redirect_valid at reset", 1'b0, redirect_valid)
      `CHK("graduate_count at reset", 2'h0, graduate_count)
      `CHK("ibuf_count at reset", 4'h0, ibuf_count)
   endtask

   // collects which result strobes were seen high over n cycles
   task automatic watch(input int n, output logic [7:0] seen);
      seen = 8'h00;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         seen = seen | {fetch_req, alu_early_bypass, alu_late_bypass, load_bypass,
            tag_mismatch, cop_issue, lsu_activate, dest_unavailable};
      end
   endtask

   // hitting loads bypass, missing loads go unavailable to the lsu, tag disagreement is
   // flagged; bubbles carrying a store bit stay quiet, real stores reach the lsu
   task automatic check_memory();
      logic [7:0] seen;
      @(posedge core_clk);
      decode_is_load <= 1'b1;
      decode_is_store <= 1'b0;
      agen_ready_vec <= 8'h01;
      force_dmiss <= 1'b1;
      watch(40, seen);
      `CHK("load strobes", 8'h9b, seen)
      @(posedge core_clk);
      decode_is_load <= 1'b0;
      decode_is_store <= 1'b1;
      agen_ready_vec <= 8'h00;
      force_dmiss <= 1'b0;
      repeat (12) @(posedge core_clk);
      watch(20, seen);
      `CHK("bubble strobes", 8'h80, seen)
      @(posedge core_clk);
      agen_ready_vec <= 8'h01;
      watch(30, seen);
      `CHK("store strobes", 8'h82, seen)
   endtask

   // compressed fetch still feeds decode, and coprocessor work issues in order
   task automatic check_cop();
      logic [7:0] seen;
      @(posedge core_clk);
      cfg_compressed <= 1'b1;
      decode_pipe <= 2'h2;
      repeat (12) @(posedge core_clk);
      watch(40, seen);
      `CHK("coprocessor strobes", 8'h84, seen)
   endtask

   // simple ops bypass early and late, other ops only from the bypass stage
   task automatic check_alu();
      logic [7:0] seen;
      @(posedge core_clk);
      decode_pipe <= 2'h0;
      alu_ready_vec <= 8'h0c;
      alu_simple_op <= 1'b1;
      repeat (12) @(posedge core_clk);
      watch(30, seen);
      `CHK("simple alu strobes", 8'he0, seen)
      @(posedge core_clk);
      alu_simple_op <= 1'b0;
      watch(20, seen);
      `CHK("full alu strobes", 8'ha0, seen)
   endtask

   // each pipe picks independently, lowest ready candidate of eight
   task automatic check_select();
      logic [7:0] tbl [6] = '{8'h01, 8'h80, 8'h40, 8'h24, 8'h00, 8'hff};
      logic [3:0] ea, eg;
      for (int i = 0; i < 6; i++) begin
         @(posedge core_clk);
         alu_ready_vec <= tbl[i];
         agen_ready_vec <= tbl[5 - i];
         ea = lowest(tbl[i]);
         eg = lowest(tbl[5 - i]);
         @(posedge core_clk);
         #1;
         `CHK("alu_select_valid", ea[3], alu_select_valid)
         `CHK("agen_select_valid", eg[3], agen_select_valid)
         if (ea[3])
            `CHK("alu_select", ea[2:0], alu_select)
         if (eg[3])
            `CHK("agen_select", eg[2:0], agen_select)
      end
   endtask

   // majority of three history votes, held steady so the result can settle
   task automatic check_vote();
      logic [2:0] v;
      for (int i = 0; i < 8; i++) begin
         v = i[2:0];
         @(posedge core_clk);
         {bht_vote2, bht_vote1, bht_vote0} <= v;
         repeat (4) @(posedge core_clk);
         #1;
         `CHK("predict_taken", (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]), predict_taken)
      end
   endtask

   // prefetch count follows the pin, with 3 held at the ceiling of two lines
   task automatic check_prefetch(input logic [1:0] lines);
      logic [1:0] seen;
      seen = 2'h0;
      @(posedge core_clk);
      cfg_prefetch_lines <= lines;
      repeat (4) @(posedge core_clk);
      force_miss <= 1'b1;
      for (int i = 0; i < 40 && seen == 2'h0; i++) begin
         @(posedge core_clk);
         #1;
         if (prefetch_pending !== 2'h0)
            seen = prefetch_pending;
      end
      `CHK("prefetch_pending", (lines > PF_MAX) ? PF_MAX : lines, seen)
      @(posedge core_clk);
      force_miss <= 1'b0;
      repeat (20) @(posedge core_clk);
   endtask

   // a late branch fault or indirect jump restarts fetch and empties the buffer
   task automatic check_redirect(input logic jump, input logic [31:0] tgt);
      logic hit;
      hit = 1'b0;
      @(posedge core_clk);
      agen_ready_vec <= 8'h01;
      decode_is_load <= jump;
      decode_is_store <= ~jump;
      alu_simple_op <= jump;
      redirect_target <= tgt;
      branch_mispredict <= ~jump;
      indirect_jump <= jump;
      for (int i = 0; i < 80 && !hit; i++) begin
         @(posedge core_clk);
         #1;
         hit = (redirect_valid === 1'b1);
      end
      `CHK("redirect_valid", 1'b1, hit)
      @(posedge core_clk);
      branch_mispredict <= 1'b0;
      indirect_jump <= 1'b0;
      #1;
      `CHK("ibuf_count after redirect", 4'h0, ibuf_count)
      `CHK("fetch_pc after redirect", {tgt[31:2], PC_ALIGN_ZERO}, fetch_pc)
      repeat (30) @(posedge core_clk);
   endtask

   initial begin
      repeat (15) @(posedge core_clk);
      check_reset();
      @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
      check_select();
      check_vote();
      for (int i = 0; i < 4; i++)
         check_prefetch(i[1:0]);
      check_redirect(1'b0, 32'h0000_1236);
      check_redirect(1'b1, 32'h0000_4a01);
      check_memory();
      check_cop();
      check_alu();
      conclude();
   end
endmodule
